// ### shared/ddrmr_pkg.sv
// Function
// - Parity checking is off by default; a latency code of 001, 010 or 011 turns it on.
// - With checking on, a command executes only after passing parity.
// - Parity covers activate strobe, three shared command pins and full address.
// - Clock enable, termination control and chip select stay out of parity.
// - Register set command with select bits 20:18 equal 110 loads this register.
// - Bits 12:10 give column spacing 4 to 8 clocks; codes above 100 reserved.
// - Bit 6 picks reference range: zero 60-92%, one 45-77% of supply.
// - Bits 5:0 give the reference step, fifty settings about 0.65% apart.
// - During calibration the reference level may appear on lower data pins.
// - Column spacing down to four clocks is accepted.
// - Latency code 000 off, 001/010/011 give 4/5/6 clocks, rest reserved.
// - A parity error sets a sticky status bit cleared by register set.
// - Without persistent mode checking stops while the status bit is set.
package ddrmr_pkg;
   localparam int ADDR_W        = 18;
   localparam int MR_W          = 22;
   localparam int SEL_LSB       = 18;
   localparam logic [2:0] SEL_MR5 = 3'h5;
   localparam logic [2:0] SEL_MR6 = 3'h6;
   localparam int SPACE_LSB     = 10;
   localparam int CAL_EN_BIT    = 7;
   localparam int RANGE_BIT     = 6;
   localparam int LEVEL_LSB     = 0;
   localparam int LEVEL_MAX     = 49;
   localparam int PLAT_LSB      = 0;
   localparam int PERR_BIT      = 4;
   localparam int PERSIST_BIT   = 9;
   localparam logic [2:0] SPACE_RST = 3'h0;
   localparam logic [2:0] PLAT_RST  = 3'h0;
   localparam logic [3:0] SPACE_BASE = 4'h4;
   localparam int MAX_LAT       = 6;

   typedef struct packed {
      logic              actN;
      logic              rasN;
      logic              casN;
      logic              weN;
      logic [1:0]        bg;
      logic [1:0]        ba;
      logic [ADDR_W-1:0] addr;
   } ddrmr_cmd_t;

   typedef struct packed {
      logic [3:0] spaceClks;
      logic       calEn;
      logic       range2;
      logic [5:0] level;
      logic       levelOk;
   } ddrmr_cfg_t;
endpackage

// ### src/ddrmr_delay.sv
module ddrmr_delay
#(
   parameter int DEPTH = 6,
   parameter int W     = 29
)
(
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         rstSyncN,
   // Stream
   input  wire logic [W-1:0] din,
   input  wire logic         vin,
   output logic [DEPTH-1:0][W-1:0] dout,
   output logic [DEPTH-1:0]  vout
);
   logic [DEPTH-1:0][W-1:0] data_ff;
   logic [DEPTH-1:0]        valid_ff;
   logic [DEPTH-1:0][W-1:0] nxt_data;
   logic [DEPTH-1:0]        nxt_valid;

   // One stage would leave the shift slice empty
   if (DEPTH < 2 || W < 1)
   begin
      $error("DEPTH must be at least two and W at least one");
   end

   always_comb
   begin
      nxt_data  = {data_ff[DEPTH-2:0], din};
      nxt_valid = {valid_ff[DEPTH-2:0], vin};
   end

   always_ff @(posedge core_clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         data_ff  <= '0;
         valid_ff <= '0;
      end
      else
      begin
         data_ff  <= nxt_data;
         valid_ff <= nxt_valid;
      end
   end

   assign dout = data_ff;
   assign vout = valid_ff;
endmodule

// ### src/ddrmr_parity.sv
module ddrmr_parity
(
   // Command in
   input  wire ddrmr_pkg::ddrmr_cmd_t cmd,
   input  wire logic                  parBit,
   // Result
   output logic                       parErr
);
   assign parErr = ^{cmd, parBit};
endmodule

// ### src/ddrmr_top.sv
module ddrmr_top
(
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   // Command pins
   input  wire logic                  ckeIn,
   input  wire logic                  odtIn,
   input  wire logic                  csN,
   input  wire ddrmr_pkg::ddrmr_cmd_t cmdIn,
   input  wire logic                  parIn,
   // Reference level monitor
   input  wire logic [5:0]            vrefLevelMon,
   // Executed command
   output logic                       execValid,
   output ddrmr_pkg::ddrmr_cmd_t      execCmd,
   // Decoded configuration
   output ddrmr_pkg::ddrmr_cfg_t      cfgOut,
   output logic [2:0]                 parLatCode,
   output logic                       parErrStatus,
   output logic                       parCheckOn,
   output logic                       vrefOnDq,
   output logic [3:0]                 dqMonOe
);
   localparam int CW        = $bits(ddrmr_pkg::ddrmr_cmd_t);
   localparam int MAX_LAT_I = ddrmr_pkg::MAX_LAT;
   localparam int MR_W_I    = ddrmr_pkg::MR_W;

   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_CHECK = 2'b01,
      ST_HOLD  = 2'b10
   } ddrmr_state_t;

   logic                 rstMeta_ff;
   logic                 rstSync_ff;
   logic                 cmdErr;
   logic                 cmdTake;
   logic [MAX_LAT_I-1:0][CW:0] pipeData;
   logic [MAX_LAT_I-1:0] pipeValid;
   logic [MAX_LAT_I-1:0] spent_ff;
   logic [MAX_LAT_I-1:0] nxt_spent;

   ddrmr_state_t         state_ff;
   ddrmr_state_t         nxt_state;
   logic [2:0]           space_ff;
   logic [2:0]           nxt_space;
   logic                 calEn_ff;
   logic                 nxt_calEn;
   logic                 range_ff;
   logic                 nxt_range;
   logic [5:0]           level_ff;
   logic [5:0]           nxt_level;
   logic [2:0]           plat_ff;
   logic [2:0]           nxt_plat;
   logic                 persist_ff;
   logic                 nxt_persist;
   logic                 perr_ff;
   logic                 nxt_perr;
   logic                 execValid_ff;
   logic                 nxt_execValid;
   ddrmr_pkg::ddrmr_cmd_t execCmd_ff;
   ddrmr_pkg::ddrmr_cmd_t nxt_execCmd;
   ddrmr_pkg::ddrmr_cfg_t cfg_ff;
   ddrmr_pkg::ddrmr_cfg_t nxt_cfg;
   logic                 checkOn_ff;
   logic                 nxt_checkOn;
   logic                 vrefOn_ff;
   logic [3:0]           dqOe_ff;
   logic [3:0]           nxt_dqOe;

   logic                 checkActive;
   logic [2:0]           latClks;
   logic                 outValid;
   logic [CW:0]          outWord;
   ddrmr_pkg::ddrmr_cmd_t outCmd;
   logic                 outErr;
   logic [MR_W_I-1:0]    opCode;
   logic                 isMrs;
   logic [2:0]           mrSel;

   // Reset release through two flops
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rstMeta_ff <= 1'b0;
         rstSync_ff <= 1'b0;
      end
      else
      begin
         rstMeta_ff <= 1'b1;
         rstSync_ff <= rstMeta_ff;
      end
   end

   // Clock enable, ODT and chip select are not inputs of the checker
   ddrmr_parity u_parity
   (
      .cmd    (cmdIn),
      .parBit (parIn),
      .parErr (cmdErr)
   );

   assign cmdTake = ckeIn && !csN;

   ddrmr_delay #(.DEPTH(MAX_LAT_I), .W(CW + 1)) u_delay
   (
      .core_clk (core_clk),
      .rstSyncN (rstSync_ff),
      .din      ({cmdIn, cmdErr}),
      .vin      (cmdTake),
      .dout     (pipeData),
      .vout     (pipeValid)
   );

   // Latency code to clock count; reserved codes read as off
   always_comb
   begin
      case (plat_ff)
         3'h1:    latClks = 3'h4;
         3'h2:    latClks = 3'h5;
         3'h3:    latClks = 3'h6;
         default: latClks = 3'h0;
      endcase
   end

   assign checkActive = (latClks != 3'h0) && (!perr_ff || persist_ff);

   // Tap the pipe at the latency; a latency change mid-stream may drop a command
   always_comb
   begin
      outValid = cmdTake;
      outWord  = {cmdIn, cmdErr};
      if (latClks != 3'h0)
      begin
         outValid = pipeValid[latClks - 3'h1] && !spent_ff[latClks - 3'h1];
         outWord  = pipeData[latClks - 3'h1];
      end
   end

   // Marks entries already taken, so a latency increase cannot replay a command
   always_comb
   begin
      nxt_spent = {spent_ff[MAX_LAT_I-2:0], 1'b0};
      if (latClks == 3'h0)
      begin
         nxt_spent[0] = cmdTake;
      end
      else if (latClks < 3'(MAX_LAT_I))
      begin
         nxt_spent[latClks] = pipeValid[latClks - 3'h1];
      end
   end

   always_ff @(posedge core_clk or negedge rstSync_ff)
   begin
      if (!rstSync_ff)
      begin
         spent_ff <= '0;
      end
      else
      begin
         spent_ff <= nxt_spent;
      end
   end

   assign outCmd = outWord[CW:1];
   assign outErr = outWord[0] && checkActive;
   assign opCode = {outCmd.bg, outCmd.ba, outCmd.addr[17], 3'h0, outCmd.addr[13:0]};
   assign mrSel  = opCode[ddrmr_pkg::SEL_LSB +: 3];
   // Only act/strobe pattern of a register set; relied on, not enforced beyond decode
   assign isMrs  = outValid && !outErr && outCmd.actN && !outCmd.rasN && !outCmd.casN
                   && !outCmd.weN;

   always_comb
   begin
      nxt_state     = state_ff;
      nxt_space     = space_ff;
      nxt_calEn     = calEn_ff;
      nxt_range     = range_ff;
      nxt_level     = level_ff;
      nxt_plat      = plat_ff;
      nxt_persist   = persist_ff;
      nxt_perr      = perr_ff;
      nxt_execValid = outValid && !outErr;
      nxt_execCmd   = outCmd;
      if (isMrs && mrSel == ddrmr_pkg::SEL_MR6)
      begin
         // Reserved bits 21, 17, 13, 9, 8 are simply not stored
         nxt_space = opCode[ddrmr_pkg::SPACE_LSB +: 3];
         nxt_calEn = opCode[ddrmr_pkg::CAL_EN_BIT];
         nxt_range = opCode[ddrmr_pkg::RANGE_BIT];
         nxt_level = opCode[ddrmr_pkg::LEVEL_LSB +: 6];
      end
      if (isMrs && mrSel == ddrmr_pkg::SEL_MR5)
      begin
         nxt_plat    = opCode[ddrmr_pkg::PLAT_LSB +: 3];
         nxt_persist = opCode[ddrmr_pkg::PERSIST_BIT];
         nxt_perr    = opCode[ddrmr_pkg::PERR_BIT];
      end
      if (outValid && outErr)
      begin
         nxt_perr = 1'b1;
      end
      // Armed while a latency is set, held off by a sticky error without persistent mode
      case (state_ff)
         ST_IDLE:
         begin
            if (latClks != 3'h0)
            begin
               nxt_state = ST_CHECK;
            end
         end
         ST_CHECK:
         begin
            if (perr_ff && !persist_ff)
            begin
               nxt_state = ST_HOLD;
            end
            else if (latClks == 3'h0)
            begin
               nxt_state = ST_IDLE;
            end
         end
         ST_HOLD:
         begin
            if (!perr_ff)
            begin
               nxt_state = ST_IDLE;
            end
         end
         default:
         begin
            nxt_state = ST_IDLE;
         end
      endcase
      nxt_checkOn = checkActive;
      nxt_cfg.spaceClks = (space_ff <= 3'h4) ? (ddrmr_pkg::SPACE_BASE + {1'b0, space_ff})
                          : 4'h0;
      nxt_cfg.calEn   = calEn_ff;
      nxt_cfg.range2  = range_ff;
      nxt_cfg.level   = level_ff;
      nxt_cfg.levelOk = (level_ff <= 6'(ddrmr_pkg::LEVEL_MAX));
      nxt_dqOe = calEn_ff ? 4'hF : 4'h0;
   end

   always_ff @(posedge core_clk or negedge rstSync_ff)
   begin
      if (!rstSync_ff)
      begin
         state_ff     <= ST_IDLE;
         space_ff     <= ddrmr_pkg::SPACE_RST;
         calEn_ff     <= 1'b0;
         range_ff     <= 1'b0;
         level_ff     <= 6'h00;
         plat_ff      <= ddrmr_pkg::PLAT_RST;
         persist_ff   <= 1'b0;
         perr_ff      <= 1'b0;
         execValid_ff <= 1'b0;
         execCmd_ff   <= '0;
         cfg_ff       <= '0;
         checkOn_ff   <= 1'b0;
         vrefOn_ff    <= 1'b0;
         dqOe_ff      <= 4'h0;
      end
      else
      begin
         state_ff     <= nxt_state;
         space_ff     <= nxt_space;
         calEn_ff     <= nxt_calEn;
         range_ff     <= nxt_range;
         level_ff     <= nxt_level;
         plat_ff      <= nxt_plat;
         persist_ff   <= nxt_persist;
         perr_ff      <= nxt_perr;
         execValid_ff <= nxt_execValid;
         execCmd_ff   <= nxt_execCmd;
         cfg_ff       <= nxt_cfg;
         checkOn_ff   <= nxt_checkOn;
         vrefOn_ff    <= nxt_cfg.calEn;
         dqOe_ff      <= nxt_dqOe;
      end
   end

   assign execValid    = execValid_ff;
   assign execCmd      = execCmd_ff;
   assign cfgOut       = cfg_ff;
   assign parLatCode   = plat_ff;
   assign parErrStatus = perr_ff;
   assign parCheckOn   = checkOn_ff;
   assign vrefOnDq     = vrefOn_ff;
   assign dqMonOe      = dqOe_ff;
endmodule

// ### verification/ddrmr_ctrl_model.sv
module ddrmr_ctrl_model
(
   // Clock
   input wire logic              core_clk,
   // Command pins
   output logic                  ckeIn, odtIn, csN, parIn,
   output ddrmr_pkg::ddrmr_cmd_t cmdIn
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      ckeIn = 1'b1;
      odtIn = 1'b0;
      csN   = 1'b1;
      parIn = 1'b0;
      cmdIn = '0;
   end
   task automatic send(input ddrmr_pkg::ddrmr_cmd_t c, input logic bad);
      @(posedge core_clk);
      odtIn <= ~odtIn;
      csN   <= 1'b0;
      cmdIn <= c;
      parIn <= ^c ^ bad;
   endtask
   // Deselected pins wander so stale values never look valid
   task automatic idle(input int n);
      repeat (n)
      begin
         @(posedge core_clk);
         csN   <= 1'b1;
         cmdIn <= ~cmdIn;
         parIn <= ~parIn;
      end
   endtask
endmodule

// ### verification/ddrmr_properties.sv
module ddrmr_props
(
   // Clock, reset, pins
   input wire logic                  core_clk, rst_n, ckeIn, csN, parIn,
   input wire ddrmr_pkg::ddrmr_cmd_t cmdIn,
   // Outputs
   input wire logic                  execValid, parErrStatus, parCheckOn, vrefOnDq,
   input wire ddrmr_pkg::ddrmr_cmd_t execCmd,
   input wire ddrmr_pkg::ddrmr_cfg_t cfgOut,
   input wire logic [2:0]            parLatCode,
   input wire logic [3:0]            dqMonOe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic        take, good, mrs, wr5, wr6;
   logic [3:0]  spc, sinceMr5_ff, nxt_sinceMr5;
   logic [12:0] xcfg;
   assign take = ckeIn & ~csN;
   assign good = ~^{cmdIn, parIn};
   assign mrs  = take & cmdIn.actN & ~|{cmdIn.rasN, cmdIn.casN, cmdIn.weN};
   assign wr5  = mrs & ({cmdIn.bg[0], cmdIn.ba} == 3'h5);
   assign wr6  = mrs & ({cmdIn.bg[0], cmdIn.ba} == 3'h6);
   assign spc  = cmdIn.addr[12:10] > 3'h4 ? 4'h0 : {1'b0, cmdIn.addr[12:10]} + 4'h4;
   assign xcfg = {spc, cmdIn.addr[7:0], cmdIn.addr[5:0] <= 6'h31};
   // Saturates so a stale clear is never mistaken for a recent one
   always_comb nxt_sinceMr5 = wr5 ? 4'h0 : sinceMr5_ff + {3'h0, ~&sinceMr5_ff};
   always_ff @(posedge core_clk or negedge rst_n)
      if (!rst_n)
         sinceMr5_ff <= 4'hF;
      else
         sinceMr5_ff <= nxt_sinceMr5;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   AST_CHECK_OFF: assert property (parCheckOn |-> $past(parLatCode) inside {3'h1, 3'h2, 3'h3})
      else $error("check on without valid latency");
   AST_LAT0: assert property (take && parLatCode == 3'h0 |=> execValid && execCmd == $past(cmdIn))
      else $error("command not run next cycle");
   AST_LAT4: assert property (take && good && parCheckOn && parLatCode == 3'h1 |-> ##5 execValid)
      else $error("latency four wrong");
   AST_LAT5: assert property (take && good && parCheckOn && parLatCode == 3'h2 |-> ##6 execValid)
      else $error("latency five wrong");
   AST_LAT6: assert property (take && good && parCheckOn && parLatCode == 3'h3 |-> ##7 execValid)
      else $error("latency six wrong");
   AST_REFUSE: assert property (take && !good && parCheckOn |-> ##1 !execValid [*7])
      else $error("bad parity command ran");
   AST_ERR_SET: assert property (take && !good && parCheckOn |-> ##[1:9] parErrStatus)
      else $error("error status not set");
   AST_ERR_CLR: assert property ($fell(parErrStatus) |-> sinceMr5_ff <= 4'hA)
      else $error("error status cleared without write");
   AST_MR6: assert property (wr6 && parLatCode == 3'h0 |-> ##2 cfgOut == $past(xcfg, 2))
      else $error("config decode wrong");
   AST_SEL: assert property (take && !wr6 && parLatCode == 3'h0 |-> ##2 $stable(cfgOut))
      else $error("config changed by other command");
   AST_DQ: assert property (dqMonOe == {4{vrefOnDq}})
      else $error("monitor enable mismatch");
endmodule

bind ddrmr_top ddrmr_props ddrmr_props_inst (.*);

// ### verification/ddrmr_top_tb.sv
module ddrmr_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic                  core_clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic [5:0]            vrefLevelMon = 6'h00;
   wire logic             ckeIn, odtIn, csN, parIn;
   ddrmr_pkg::ddrmr_cmd_t cmdIn, execCmd, c;
   ddrmr_pkg::ddrmr_cfg_t cfgOut;
   logic [2:0]            parLatCode;
   logic                  execValid, parErrStatus, parCheckOn, vrefOnDq;
   logic [3:0]            dqMonOe;
   logic [5:0]            lvl;
   logic                  rb;
   ddrmr_pkg::ddrmr_cmd_t expQ[$];
   int                    bad_count = 0;
   int                    n_checks = 0;
   logic [31:0]           rng = 32'h00009BC3;
   ddrmr_top ddrmr_top_inst (.*);
   ddrmr_ctrl_model ddrmr_ctrl_model_inst (.*);
   always #20 core_clk = ~core_clk;
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   function automatic ddrmr_pkg::ddrmr_cmd_t mrs(logic [2:0] sel, logic [13:0] op);
      mrs = '0;
      mrs.actN = 1'b1;
      mrs.bg = {1'b0, sel[2]};
      mrs.ba = sel[1:0];
      mrs.addr[13:0] = op;
   endfunction
   function automatic ddrmr_pkg::ddrmr_cmd_t act();
      act = ddrmr_pkg::ddrmr_cmd_t'(xs());
      act.actN = 1'b0;
   endfunction
   task automatic chk(string name, logic [31:0] e, logic [31:0] s);
      n_checks++;
      if (e !== s)
      begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", name, e, s);
      end
   endtask
   task automatic go(ddrmr_pkg::ddrmr_cmd_t cm, logic bad, logic ex, int gap);
      ddrmr_ctrl_model_inst.send(cm, bad);
      if (ex)
         expQ.push_back(cm);
      ddrmr_ctrl_model_inst.idle(gap);
      #1;
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge core_clk) vrefLevelMon <= 6'(xs());
   always @(negedge core_clk)
      if (execValid === 1'b1)
      begin
         if (expQ.size() == 0)
            chk("extra exec", 32'h0, 32'h1);
         else
            chk("execCmd", expQ.pop_front(), execCmd);
      end
   initial
   begin
      repeat (5000) @(posedge core_clk);
      bad_count++;
      give_verdict();
   end
   initial
   begin
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk("reset", {ddrmr_pkg::SPACE_BASE, 8'h00, 1'b1, 9'h000},
          {cfgOut, parLatCode, parCheckOn, parErrStatus, dqMonOe});
      for (int i = 0; i < 8; i++)
      begin
         lvl = i == 0 ? 6'h31 : i == 1 ? 6'h32 : 6'(xs());
         rb = rng[9];
         c = mrs(3'h6, {1'b0, 3'(i), 2'h0, 1'b1, rb, lvl});
         go(c, 1'b0, 1'b1, 3);
         chk("cfgOut", {i < 5 ? 4'(i + 4) : 4'h0, 1'b1, rb, lvl, lvl < 6'h32}, cfgOut);
         chk("dq", 5'h1F, {vrefOnDq, dqMonOe});
      end
      go(mrs(3'h6, 14'h0400), 1'b0, 1'b1, 3);
      chk("cfgOff", 18'h14020, {cfgOut, vrefOnDq, dqMonOe});
      for (int s = 0; s < 8; s++)
         if (s != 5 && s != 6)
         begin
            go(mrs(3'(s), 14'(xs())), 1'b0, 1'b1, 3);
            chk("cfgKeep", 12'hA01, cfgOut);
         end
      go(act(), 1'b1, 1'b1, 0);
      go(act(), 1'b0, 1'b1, 4);
      for (int k = 1; k < 4; k++)
      begin
         go(mrs(3'h5, 14'(k)), 1'b0, 1'b1, 9);
         chk("lat", {3'(k), 1'b1}, {parLatCode, parCheckOn});
         go(act(), 1'b0, 1'b1, 0);
         go(act(), 1'b0, 1'b1, 10);
         go(act(), 1'b1, 1'b0, 10);
         chk("errSet", 2'h2, {parErrStatus, parCheckOn});
         go(act(), 1'b1, 1'b1, 10);
         go(mrs(3'h5, 14'h0200 | 14'(k)), 1'b0, 1'b1, 10);
         chk("errClr", 1'b0, parErrStatus);
         go(act(), 1'b1, 1'b0, 10);
         go(act(), 1'b1, 1'b0, 10);
         chk("persist", 2'h3, {parErrStatus, parCheckOn});
         go(mrs(3'h5, 14'(k)), 1'b0, 1'b1, 10);
      end
      go(mrs(3'h5, 14'h0004), 1'b0, 1'b1, 10);
      chk("reserved", 4'h8, {parLatCode, parCheckOn});
      go(act(), 1'b1, 1'b1, 12);
      chk("pending", 32'h0, expQ.size());
      give_verdict();
   end
endmodule
